// [inc/tdr_pkg.sv]
package tdr_pkg;

  localparam int ENTRIES = 64;
  localparam logic [5:0] LAST_ENTRY = 6'h3F;

  // operation codes from the pipeline
  typedef enum logic [2:0] {
    OP_NOP, OP_TRANSLATE, OP_BYPASS, OP_DEMAP,
    OP_READ, OP_WRITE, OP_INVAL_ALL, OP_INVAL_LOAD
  } tdr_op_t;

  // demap type and context select encodings
  localparam logic [1:0] DMT_PAGE = 2'h0;
  localparam logic [1:0] DMT_CONTEXT = 2'h1;
  localparam logic [1:0] DMT_ALL = 2'h2;
  localparam logic [1:0] CSEL_PRIMARY = 2'h0;
  localparam logic [1:0] CSEL_SECONDARY = 2'h1;
  localparam logic [1:0] CSEL_NUCLEUS = 2'h2;

  // demap address fields
  localparam int DM_TYPE_LO = 6;
  localparam int DM_CSEL_LO = 4;
  localparam int DM_REAL = 9;

  // page sizes
  localparam logic [1:0] SZ_8K = 2'h0;
  localparam logic [1:0] SZ_64K = 2'h1;
  localparam logic [1:0] SZ_4M = 2'h2;
  localparam logic [1:0] SZ_256M = 2'h3;
  localparam logic [34:0] MASK_64K = 35'h7FFFFFFF8;
  localparam logic [34:0] MASK_4M = 35'h7FFFFFE00;
  localparam logic [34:0] MASK_256M = 35'h7FFFF8000;

  // tag word layout
  localparam int TAG_PID_LO = 61;
  localparam int TAG_REAL = 60;
  localparam int TAG_SIZE_LO = 56;
  localparam int VA_HI = 47;
  localparam int VA_LO = 13;
  // data word layout
  localparam int DAT_VALID = 63;
  localparam int DAT_LOCK = 62;
  localparam int DAT_USED = 61;
  localparam int PA_HI = 39;
  localparam int PA_LO = 13;

  localparam logic [7:0] BYPASS_ATTR = 8'h00;

  // apb register byte offsets
  localparam logic [7:0] REG_PID = 8'h00;
  localparam logic [7:0] REG_CTX_PRI = 8'h04;
  localparam logic [7:0] REG_CTX_SEC = 8'h08;
  localparam logic [7:0] REG_CTX_NUC = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;

  typedef struct packed {
    logic valid;
    logic used;
    logic lock;
    logic realPage;
    logic [2:0] pid;
    logic [1:0] size;
    logic [34:0] vpn;
    logic [12:0] ctx;
    logic [26:0] ppn;
    logic [7:0] attr;
  } tdr_entry_t;

  typedef struct packed {
    tdr_entry_t [ENTRIES-1:0] ent;
    logic [2:0] pid;
    logic [12:0] ctxPri;
    logic [12:0] ctxSec;
    logic [12:0] ctxNuc;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic resValid;
    logic resHit;
    logic resFault;
    logic [39:0] resPa;
    logic [7:0] resAttr;
    logic [63:0] resData;
  } tdr_state_t;

endpackage : tdr_pkg

// [logic/tdr_tlb.sv]
// Our own choices: the APB slave port and the address map.
module tdr_tlb
  import tdr_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire tdr_op_t opCode,
  input wire logic [63:0] opVa,
  input wire logic [12:0] opCtx,
  input wire logic opReal,
  input wire logic [5:0] opIndex,
  input wire logic opAuto,
  input wire logic opTagSel,
  input wire logic [63:0] opWrTag,
  input wire logic [63:0] opWrData,
  output logic resValid,
  output logic resHit,
  output logic resFault,
  output logic [39:0] resPa,
  output logic [7:0] resAttr,
  output logic [63:0] resData
);

  tdr_state_t s_q;
  tdr_state_t s_d;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [34:0] sizeMask(input logic [1:0] sz);
    case (sz)
      SZ_64K: sizeMask = MASK_64K;
      SZ_4M: sizeMask = MASK_4M;
      SZ_256M: sizeMask = MASK_256M;
      default: sizeMask = '1;
    endcase
  endfunction : sizeMask

  function automatic logic vpnMatch(input tdr_entry_t e,
                                    input logic [34:0] vpn);
    logic [34:0] m;
    m = sizeMask(e.size);
    vpnMatch = ((e.vpn ^ vpn) & m) == '0;
  endfunction : vpnMatch

  // ----------------------------------------------------------------
  // per-entry match terms
  // ----------------------------------------------------------------
  logic [ENTRIES-1:0] transHit;
  logic [ENTRIES-1:0] demapHit;
  logic [ENTRIES-1:0] freeSlot;
  logic [ENTRIES-1:0] lockedAll;
  logic [ENTRIES-1:0] usedNow;
  logic [34:0] opVpn;
  logic [1:0] dmType;
  logic [1:0] dmCsel;
  logic dmReal;
  logic [12:0] dmCtx;

  assign opVpn = opVa[VA_HI:VA_LO];
  assign dmType = opVa[DM_TYPE_LO+1:DM_TYPE_LO];
  assign dmCsel = opVa[DM_CSEL_LO+1:DM_CSEL_LO];
  assign dmReal = opVa[DM_REAL];

  always_comb begin
    case (dmCsel)
      CSEL_SECONDARY: dmCtx = s_q.ctxSec;
      CSEL_NUCLEUS: dmCtx = s_q.ctxNuc;
      default: dmCtx = s_q.ctxPri;
    endcase
  end

  for (genvar i = 0; i < ENTRIES; i++) begin : g_ent
    tdr_entry_t e;
    logic pidOk;
    logic ctxOk;
    assign e = s_q.ent[i];
    assign pidOk = e.valid && e.pid == s_q.pid;
    assign ctxOk = e.realPage || e.ctx == dmCtx;
    assign transHit[i] = pidOk && e.realPage == opReal && vpnMatch(e, opVpn)
                         && (e.realPage || e.ctx == opCtx);
    always_comb begin
      case (dmType)
        DMT_PAGE: demapHit[i] = pidOk && e.realPage == dmReal
                                && vpnMatch(e, opVpn) && ctxOk;
        DMT_CONTEXT: demapHit[i] = pidOk && !e.realPage
                                   && dmCsel != CSEL_SECONDARY
                                   && e.ctx == dmCtx;
        DMT_ALL: demapHit[i] = pidOk && !e.lock;
        default: demapHit[i] = 1'b0;
      endcase
    end
    assign freeSlot[i] = !e.valid || !e.used;
    assign lockedAll[i] = e.lock;
    assign usedNow[i] = e.used;
  end

  // ----------------------------------------------------------------
  // priority pickers
  // ----------------------------------------------------------------
  logic [5:0] hitIdx;
  logic anyHit;
  logic [5:0] replIdx;
  logic anyFree;

  always_comb begin
    hitIdx = '0;
    anyHit = 1'b0;
    replIdx = LAST_ENTRY;
    anyFree = 1'b0;
    for (int k = ENTRIES - 1; k >= 0; k--) begin
      if (transHit[k]) begin
        hitIdx = 6'(k);
        anyHit = 1'b1;
      end
      if (freeSlot[k]) begin
        replIdx = 6'(k);
        anyFree = 1'b1;
      end
    end
    // all busy, take first unlocked, else last
    if (!anyFree) begin
      replIdx = LAST_ENTRY;
      for (int k = ENTRIES - 1; k >= 0; k--) begin
        if (!lockedAll[k]) begin
          replIdx = 6'(k);
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  logic apbAccess;
  logic [6:0] validCount;

  assign apbAccess = psel && penable && !s_q.pready;

  always_comb begin
    validCount = '0;
    for (int k = 0; k < ENTRIES; k++) begin
      validCount = validCount + 7'(s_q.ent[k].valid);
    end
  end

  // ----------------------------------------------------------------
  // entry words
  // ----------------------------------------------------------------
  tdr_entry_t rdEnt;
  tdr_entry_t wrEnt;
  logic [63:0] tagWord;
  logic [63:0] dataWord;

  assign rdEnt = s_q.ent[opIndex];

  always_comb begin
    wrEnt = '0;
    wrEnt.pid = opWrTag[TAG_PID_LO+2:TAG_PID_LO];
    wrEnt.realPage = opWrTag[TAG_REAL];
    wrEnt.size = opWrTag[TAG_SIZE_LO+1:TAG_SIZE_LO];
    wrEnt.vpn = opWrTag[VA_HI:VA_LO];
    wrEnt.ctx = opWrTag[VA_LO-1:0];
    wrEnt.valid = opWrData[DAT_VALID];
    wrEnt.lock = opWrData[DAT_LOCK];
    wrEnt.ppn = opWrData[PA_HI:PA_LO];
    wrEnt.attr = opWrData[7:0];
  end

  // tag word of the indexed entry
  always_comb begin
    tagWord = '0;
    tagWord[TAG_PID_LO+2:TAG_PID_LO] = rdEnt.pid;
    tagWord[TAG_REAL] = rdEnt.realPage;
    tagWord[TAG_SIZE_LO+1:TAG_SIZE_LO] = rdEnt.size;
    tagWord[VA_HI:VA_LO] = rdEnt.vpn;
    tagWord[VA_LO-1:0] = rdEnt.ctx;
  end

  // data word of the indexed entry
  always_comb begin
    dataWord = '0;
    dataWord[DAT_VALID] = rdEnt.valid;
    dataWord[DAT_LOCK] = rdEnt.lock;
    dataWord[DAT_USED] = rdEnt.used;
    dataWord[PA_HI:PA_LO] = rdEnt.ppn;
    dataWord[7:0] = rdEnt.attr;
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  logic [5:0] wIdx;
  logic [ENTRIES-1:0] usedSet;
  logic doUsed;

  always_comb begin
    s_d = s_q;
    wIdx = opAuto ? replIdx : opIndex;
    usedSet = usedNow;
    doUsed = 1'b0;
    s_d.resValid = 1'b0;
    s_d.resHit = 1'b0;
    s_d.resFault = 1'b0;
    s_d.pready = 1'b0;
    s_d.pslverr = 1'b0;

    case (opCode)
      OP_TRANSLATE: begin
        s_d.resValid = 1'b1;
        s_d.resHit = anyHit;
        s_d.resPa = {s_q.ent[hitIdx].ppn, opVa[PA_LO-1:0]};
        s_d.resAttr = s_q.ent[hitIdx].attr;
        if (anyHit) begin
          usedSet[hitIdx] = 1'b1;
          doUsed = 1'b1;
        end
      end
      OP_BYPASS: begin
        s_d.resValid = 1'b1;
        s_d.resHit = 1'b1;
        s_d.resPa = opVa[PA_HI:0];
        s_d.resAttr = BYPASS_ATTR;
      end
      OP_DEMAP: begin
        for (int k = 0; k < ENTRIES; k++) begin
          if (demapHit[k]) begin
            s_d.ent[k].valid = 1'b0;
          end
        end
      end
      OP_READ: begin
        // tag or data, one per request
        s_d.resValid = 1'b1;
        if (opTagSel) begin
          s_d.resData = tagWord;
        end else begin
          s_d.resData = dataWord;
        end
      end
      OP_WRITE: begin
        // tag and data in one cycle
        s_d.ent[wIdx] = wrEnt;
        usedSet[wIdx] = 1'b1;
        doUsed = 1'b1;
      end
      OP_INVAL_ALL: begin
        for (int k = 0; k < ENTRIES; k++) begin
          s_d.ent[k].valid = 1'b0;
        end
      end
      OP_INVAL_LOAD: begin
        s_d.resValid = 1'b1;
        s_d.resFault = 1'b1;
      end
      default: begin
      end
    endcase

    if (doUsed) begin
      for (int k = 0; k < ENTRIES; k++) begin
        if (&usedSet) begin
          s_d.ent[k].used = usedSet[k] && s_d.ent[k].lock;
        end else begin
          s_d.ent[k].used = usedSet[k];
        end
      end
    end

    // apb slave, one wait state
    if (apbAccess) begin
      s_d.pready = 1'b1;
      s_d.prdata = '0;
      case (paddr)
        REG_PID: begin
          if (pwrite) s_d.pid = pwdata[2:0];
          s_d.prdata[2:0] = s_q.pid;
        end
        REG_CTX_PRI: begin
          if (pwrite) s_d.ctxPri = pwdata[12:0];
          s_d.prdata[12:0] = s_q.ctxPri;
        end
        REG_CTX_SEC: begin
          if (pwrite) s_d.ctxSec = pwdata[12:0];
          s_d.prdata[12:0] = s_q.ctxSec;
        end
        REG_CTX_NUC: begin
          if (pwrite) s_d.ctxNuc = pwdata[12:0];
          s_d.prdata[12:0] = s_q.ctxNuc;
        end
        REG_STATUS: begin
          s_d.prdata[6:0] = validCount;
        end
        default: begin
          s_d.pslverr = 1'b1;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign resValid = s_q.resValid;
  assign resHit = s_q.resHit;
  assign resFault = s_q.resFault;
  assign resPa = s_q.resPa;
  assign resAttr = s_q.resAttr;
  assign resData = s_q.resData;

endmodule : tdr_tlb

// [tb/tdr_tlb_monitor.sv]
module tdr_tlb_monitor
  import tdr_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire tdr_op_t opCode,
  input wire logic [63:0] opVa,
  input wire logic resValid,
  input wire logic resHit,
  input wire logic resFault,
  input wire logic [39:0] resPa,
  input wire logic [7:0] resAttr
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [39:0] vaLow;
  assign vaLow = opVa[39:0];
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);
  sequence s_clear;
    opCode == OP_INVAL_ALL ##1 opCode == OP_TRANSLATE;
  endsequence
  property p_answer;
    opCode inside {OP_TRANSLATE, OP_BYPASS, OP_READ, OP_INVAL_LOAD}
      |=> resValid;
  endproperty
  property p_quiet;
    opCode inside {OP_NOP, OP_DEMAP, OP_WRITE, OP_INVAL_ALL}
      |=> !resValid && !resFault;
  endproperty
  property p_bypass;
    opCode == OP_BYPASS |=> resHit && resAttr == BYPASS_ATTR
      && resPa == $past(vaLow);
  endproperty
  property p_fault;
    resFault |-> resValid && $past(opCode) == OP_INVAL_LOAD;
  endproperty
  property p_clear;
    s_clear |=> !resHit;
  endproperty
  property p_wait;
    psel && penable && !pready |=> pready;
  endproperty
  property p_pulse;
    pready |=> !pready;
  endproperty
  property p_hit;
    resHit |-> resValid;
  endproperty
  a_answer: assert property (p_answer)
    else $error("no result pulse");
  a_quiet: assert property (p_quiet)
    else $error("unexpected result");
  a_bypass: assert property (p_bypass)
    else $error("bypass result wrong");
  a_fault: assert property (p_fault)
    else $error("fault without load");
  a_clear: assert property (p_clear)
    else $error("hit after invalidate");
  a_wait: assert property (p_wait)
    else $error("ready late");
  a_pulse: assert property (p_pulse)
    else $error("ready too long");
  a_hit: assert property (p_hit)
    else $error("hit without result");
endmodule : tdr_tlb_monitor

bind tdr_tlb tdr_tlb_monitor u_mon (.clock(clock), .reset(reset),
  .psel(psel), .penable(penable), .pready(pready), .opCode(opCode),
  .opVa(opVa), .resValid(resValid), .resHit(resHit),
  .resFault(resFault), .resPa(resPa), .resAttr(resAttr));

// [tb/tdr_pipe_model.sv]
module tdr_pipe_model
  import tdr_pkg::*;
(
  input wire logic clock,
  output tdr_op_t opCode,
  output logic [63:0] opVa,
  output logic [12:0] opCtx,
  output logic opReal,
  output logic [5:0] opIndex,
  output logic opAuto,
  output logic opTagSel,
  output logic [63:0] opWrTag,
  output logic [63:0] opWrData
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    opCode = OP_NOP;
    {opVa, opCtx, opReal, opIndex, opAuto, opTagSel} = '0;
    {opWrTag, opWrData} = '0;
  end
  task automatic issue(input tdr_op_t c, input logic [63:0] v,
      input logic [5:0] i, input logic [1:0] f, input logic [63:0] t,
      input logic [63:0] d);
    @(posedge clock);
    opCode <= c;
    opVa <= v;
    opCtx <= t[12:0];
    opReal <= t[TAG_REAL];
    opIndex <= i;
    {opAuto, opTagSel} <= f;
    opWrTag <= t;
    opWrData <= d;
  endtask : issue
  task automatic idle();
    @(posedge clock);
    opCode <= OP_NOP;
    opVa <= ~opVa;
    opWrTag <= ~opWrTag;
  endtask : idle
endmodule : tdr_pipe_model

// [tb/test_tdr_tlb.sv]
module test_tdr_tlb
  import tdr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, er;
  tdr_op_t opCode;
  logic [63:0] opVa, opWrTag, opWrData, resData, v, tr;
  logic [12:0] opCtx, ctxP;
  logic opReal, opAuto, opTagSel, resValid, resHit, resFault;
  logic [5:0] opIndex;
  logic [39:0] resPa;
  logic [7:0] resAttr;
  logic [63:0] va [5], tg [5], dt [5];
  int n_fail = 0;
  int comparisons = 0;
  int cycles = 0;
  always #2 clock = ~clock;
  tdr_pipe_model u_pipe (.clock(clock), .opCode(opCode), .opVa(opVa),
    .opCtx(opCtx), .opReal(opReal), .opIndex(opIndex), .opAuto(opAuto),
    .opTagSel(opTagSel), .opWrTag(opWrTag), .opWrData(opWrData));
  tdr_tlb DUT (.clock(clock), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .opCode(opCode), .opVa(opVa), .opCtx(opCtx), .opReal(opReal),
    .opIndex(opIndex), .opAuto(opAuto), .opTagSel(opTagSel),
    .opWrTag(opWrTag), .opWrData(opWrData), .resValid(resValid),
    .resHit(resHit), .resFault(resFault), .resPa(resPa),
    .resAttr(resAttr), .resData(resData));
  task automatic end_of_test();
    if (n_fail == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_of_test
  task automatic check(input string n, input logic [63:0] s, e);
    comparisons++;
    if (s !== e) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask : check
  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic op(input tdr_op_t c, input logic [63:0] x,
      input logic [5:0] i, input logic [1:0] f, input logic [63:0] t,
      input logic [63:0] d);
    u_pipe.issue(c, x, i, f, t, d);
    u_pipe.idle();
    #1;
  endtask : op
  task automatic sweep(input logic [4:0] m);
    for (int i = 0; i < 5; i++) begin
      op(OP_TRANSLATE, va[i], 6'h00, 2'h0, tg[i], 64'h0);
      check("hit", 64'(resHit), 64'(m[i]));
      if (m[i]) check("pa", 64'({resAttr, resPa}),
        64'({dt[i][7:0], dt[i][39:13], va[i][12:0]}));
    end
  endtask : sweep
  function automatic logic [63:0] dm(logic [63:0] x, logic [1:0] ty,
      logic [1:0] cs);
    return {x[63:13], 3'($urandom), 1'b0, 1'($urandom), ty, cs, 4'h0};
  endfunction : dm
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_fail++;
      end_of_test();
    end
  end
  initial begin
    void'($urandom(32'h27AD));
    ctxP = 13'($urandom);
    for (int i = 0; i < 5; i++) begin
      va[i] = {16'h0, 16'(i), $urandom};
      tg[i] = {i == 3 ? 3'h4 : 3'h5, 5'h0, 8'h0, va[i][47:13],
        i == 2 || i == 4 ? ctxP + 13'h1 : ctxP};
      dt[i] = {1'b1, i == 2, 22'h0, 27'($urandom), 5'h0, 8'($urandom)};
    end
    repeat (5) @(posedge clock);
    reset <= 1'b0;
    apb(1'b1, REG_PID, 32'h5);
    apb(1'b1, REG_CTX_PRI, 32'(ctxP));
    apb(1'b1, REG_CTX_SEC, 32'(ctxP));
    apb(1'b0, REG_CTX_PRI, 32'h0);
    check("ctx", 64'(rd), 64'(ctxP));
    apb(1'b0, 8'h40, 32'h0);
    check("slverr", 64'(er), 64'h1);
    for (int i = 0; i < 5; i++)
      op(OP_WRITE, 64'h0, 6'(i), 2'h0, tg[i], dt[i]);
    apb(1'b1, REG_STATUS, 32'h0);
    apb(1'b0, REG_STATUS, 32'h0);
    check("count", 64'(rd), 64'h5);
    op(OP_READ, 64'h0, 6'h1, 2'h1, 64'h0, 64'h0);
    check("tag", resData, tg[1]);
    op(OP_READ, 64'h0, 6'h1, 2'h0, 64'h0, 64'h0);
    check("data", resData, dt[1] | 64'h2000000000000000);
    sweep(5'b10111);
    v = {$urandom, $urandom};
    op(OP_BYPASS, v, 6'h0, 2'h0, 64'h0, 64'h0);
    check("bypass", 64'(resPa), 64'(v[39:0]));
    op(OP_DEMAP, dm(va[0], DMT_PAGE, CSEL_PRIMARY), 6'h0, 2'h0, 0, 0);
    sweep(5'b10110);
    op(OP_DEMAP, dm(va[1], DMT_CONTEXT, CSEL_SECONDARY), 6'h0, 2'h0, 0, 0);
    op(OP_DEMAP, dm(va[1], 2'h3, CSEL_PRIMARY), 6'h0, 2'h0, 0, 0);
    sweep(5'b10110);
    op(OP_DEMAP, dm(va[1], DMT_CONTEXT, CSEL_PRIMARY), 6'h0, 2'h0, 0, 0);
    sweep(5'b10100);
    op(OP_DEMAP, dm(va[1], DMT_ALL, CSEL_NUCLEUS), 6'h0, 2'h0, 0, 0);
    sweep(5'b00100);
    apb(1'b1, REG_PID, 32'h4);
    op(OP_TRANSLATE, va[3], 6'h0, 2'h0, tg[3], 64'h0);
    check("pid", 64'(resHit), 64'h1);
    u_pipe.issue(OP_INVAL_ALL, 64'h0, 6'h0, 2'h0, 64'h0, 64'h0);
    u_pipe.issue(OP_TRANSLATE, va[3], 6'h0, 2'h0, tg[3], 64'h0);
    u_pipe.idle();
    #1;
    check("inval", 64'(resHit), 64'h0);
    op(OP_INVAL_LOAD, 64'h0, 6'h0, 2'h0, 64'h0, 64'h0);
    check("fault", 64'(resFault), 64'h1);
    op(OP_WRITE, 64'h0, 6'h3F, 2'h2, tg[2], dt[2]);
    op(OP_READ, 64'h0, 6'h0, 2'h1, 64'h0, 64'h0);
    check("replace", resData, tg[2]);
    tr = {3'h4, 1'b1, 2'h0, SZ_64K, 8'h0, va[0][47:13], ~ctxP};
    op(OP_WRITE, 64'h0, 6'h5, 2'h0, tr, dt[0]);
    op(OP_TRANSLATE, va[0] ^ 64'h6000, 6'h0, 2'h0, {tr[63:13], ctxP}, 0);
    check("real", 64'(resHit), 64'h1);
    check("realpa", 64'({resAttr, resPa}),
      64'({dt[0][7:0], dt[0][39:13], va[0][12:0]}));
    v = dm(va[0] ^ 64'h4000, DMT_PAGE, CSEL_SECONDARY) | 64'h200;
    op(OP_DEMAP, v, 6'h0, 2'h0, 0, 0);
    op(OP_TRANSLATE, va[0], 6'h0, 2'h0, {tr[63:13], ctxP}, 0);
    check("realdemap", 64'(resHit), 64'h0);
    for (int k = 0; k < ENTRIES; k++)
      op(OP_WRITE, 64'h0, 6'(k), 2'h0, tg[0], dt[1]);
    op(OP_READ, 64'h0, 6'h5, 2'h0, 64'h0, 64'h0);
    check("used", resData, dt[1]);
    for (int k = 0; k < ENTRIES; k++)
      op(OP_WRITE, 64'h0, 6'(k), 2'h0, tg[0], dt[2]);
    op(OP_WRITE, 64'h0, 6'h0, 2'h2, tg[1], dt[1]);
    op(OP_READ, 64'h0, LAST_ENTRY, 2'h1, 64'h0, 64'h0);
    check("locked", resData, tg[1]);
    end_of_test();
  end
endmodule : test_tdr_tlb
